/* File: rtl/pdpc_pkg.sv */
// Summary of operation
// - Port 4 has eight pins, per-bit direction.
// - Falling edge on port 4 sets key flag.
// - Memory expansion mode turns port 4 into bus.
// - Memory expansion mode keeps selected pull-ups connected.
// - Port 5 eight pins; upper address in expansion.
// - Port 6 bits 4-7; bus control in expansion.
// - Wait pin stays a port pin without wait.
// - Port 7 six pins shared with timer functions.
// - Port 8 bit 0, shared as chip select.
// - Reset loads every direction register with FFH.
// - Direction 0 is output, 1 is input.
// - Direction registers take bit or byte writes.
// - Reset clears every pull-up select register.
// - Pull-up follows select bit regardless of direction.
// - Pull-up select 0 disconnects the pull-up.
// - Pull-up select 1 connects the pull-up.
// - Port 0 driven level change raises request.
// - Port 1 is input only, no registers.
package pdpc_pkg;

  localparam int NPORT = 8;

  // Index of each register-controlled port; port 1 has none.
  localparam int P0 = 0;
  localparam int P2 = 1;
  localparam int P3 = 2;
  localparam int P4 = 3;
  localparam int P5 = 4;
  localparam int P6 = 5;
  localparam int P7 = 6;
  localparam int P8 = 7;

  localparam logic [NPORT-1:0][15:0] DIR_ADDR = {
    16'hff28, 16'hff27, 16'hff26, 16'hff25,
    16'hff24, 16'hff23, 16'hff22, 16'hff20};
  localparam logic [NPORT-1:0][15:0] PULL_ADDR = {
    16'hff38, 16'hff37, 16'hff36, 16'hff35,
    16'hff34, 16'hff33, 16'hff32, 16'hff30};

  // Implemented bit positions of each port.
  localparam logic [NPORT-1:0][7:0] DIR_MASK = {
    8'h01, 8'h3f, 8'hf0, 8'hff, 8'hff, 8'h7f, 8'h3f, 8'h0f};
  localparam logic [NPORT-1:0][7:0] PULL_MASK = {
    8'h01, 8'h3f, 8'hf0, 8'hff, 8'hff, 8'h70, 8'h3f, 8'h0f};

  localparam logic [7:0] DIR_RST  = 8'hff;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] ALL_ONE  = 8'hff;
  localparam logic [7:0] NONE     = 8'h00;

  // Port 6 bus control: bit 7 strobe, 6 wait, 5 write, 4 read.
  localparam int WAIT_BIT  = 6;
  localparam int STB_BIT   = 7;
  localparam int WR_BIT    = 5;
  localparam int RD_BIT    = 4;
  localparam int CS_BIT    = 0;
  localparam int TMR_W     = 6;
  localparam int P0_W      = 4;

  typedef struct packed {
    logic [7:0] own;
    logic [7:0] dout;
    logic [7:0] oe;
  } pdpc_alt_s;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull;
  } pdpc_drive_s;

endpackage : pdpc_pkg

/* File: rtl/pdpc_port_drive.sv */
`timescale 1ns/1ps
module pdpc_port_drive #(
  parameter logic [7:0] DMASK = 8'hff,
  parameter logic [7:0] PMASK = 8'hff
) (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst,
  // Control.
  input  wire logic [7:0]         dir,
  input  wire logic [7:0]         pull,
  input  wire logic [7:0]         latch,
  input  wire pdpc_pkg::pdpc_alt_s alt,
  // Pin side.
  output pdpc_pkg::pdpc_drive_s   drv
);

  pdpc_pkg::pdpc_drive_s st;
  pdpc_pkg::pdpc_drive_s next_st;

  always_comb begin
    next_st      = st;
    next_st.oe   = ((~dir & ~alt.own) | (alt.own & alt.oe)) & DMASK;
    next_st.dout = (alt.own & alt.dout) | (~alt.own & latch);
    next_st.pull = pull & PMASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign drv = st;

endmodule : pdpc_port_drive

/* File: rtl/pdpc_top.sv */
`timescale 1ns/1ps
module pdpc_top (
  // Clock and reset.
  input  wire logic                                   clock,
  input  wire logic                                   rst,
  // Processor register access.
  input  wire logic [15:0]                            cpu_addr,
  input  wire logic                                   cpu_wr,
  input  wire logic                                   cpu_rd,
  input  wire logic                                   cpu_bit,
  input  wire logic [2:0]                             cpu_bit_idx,
  input  wire logic [7:0]                             cpu_wdata,
  output logic [7:0]                                  cpu_rdata,
  // Output latches and alternate functions.
  input  wire logic [pdpc_pkg::NPORT-1:0][7:0]        output_latch_regs,
  input  wire pdpc_pkg::pdpc_alt_s [pdpc_pkg::NPORT-1:0] alt_in,
  // Memory expansion bus.
  input  wire logic                                   mem_mode,
  input  wire logic                                   wait_en,
  input  wire logic [7:0]                             bus_ad_out,
  input  wire logic                                   bus_ad_oe,
  input  wire logic [7:0]                             bus_addr_hi,
  input  wire logic                                   bus_rd_n,
  input  wire logic                                   bus_wr_n,
  input  wire logic                                   bus_astb,
  output logic                                        bus_wait_n,
  // Pins.
  input  wire logic [pdpc_pkg::NPORT-1:0][7:0]        pin_in,
  output pdpc_pkg::pdpc_drive_s [pdpc_pkg::NPORT-1:0] pins,
  // Events and shared inputs.
  input  wire logic                                   key_flag_clr,
  output logic                                        key_edge_request_flag,
  output logic [pdpc_pkg::P0_W-1:0]                   port0_change,
  output logic                                        chip_select_n,
  output logic [pdpc_pkg::TMR_W-1:0]                  timer_in
);

  typedef struct packed {
    logic [pdpc_pkg::NPORT-1:0][7:0] dir;
    logic [pdpc_pkg::NPORT-1:0][7:0] pull;
    logic [7:0]                      rdata;
    logic [7:0]                      key_prev;
    logic                            key_flag;
    logic [pdpc_pkg::P0_W-1:0]       p0_prev;
    logic [pdpc_pkg::P0_W-1:0]       p0_chg;
    logic                            cs_n;
    logic [pdpc_pkg::TMR_W-1:0]      tmr;
    logic                            wait_n;
  } pdpc_state_s;

  localparam pdpc_state_s RST_STATE = '{
    dir:      {pdpc_pkg::NPORT{pdpc_pkg::DIR_RST}},
    pull:     {pdpc_pkg::NPORT{pdpc_pkg::PULL_RST}},
    rdata:    8'h00,
    key_prev: 8'hff,
    key_flag: 1'b0,
    p0_prev:  4'hf,
    p0_chg:   4'h0,
    cs_n:     1'b1,
    tmr:      6'h00,
    wait_n:   1'b1
  };

  pdpc_state_s         st;
  pdpc_state_s         next_st;
  pdpc_pkg::pdpc_alt_s alt_eff [pdpc_pkg::NPORT];
  logic [7:0]          key_fall;

  // Byte write, or single-bit write of cpu_wdata[0], then unbuilt bits forced.
  function automatic logic [7:0] merge_write(
    input logic [7:0] old,
    input logic [7:0] mask,
    input logic [7:0] fill,
    input logic       bit_op,
    input logic [2:0] idx,
    input logic [7:0] wdata
  );
    logic [7:0] v;
    v = old;
    if (bit_op) begin
      v[idx] = wdata[0];
    end else begin
      v = wdata;
    end
    return (v & mask) | (fill & ~mask);
  endfunction : merge_write

  // Alternate ownership, with memory expansion overriding ports 4 to 6.
  always_comb begin
    for (int i = 0; i < pdpc_pkg::NPORT; i++) begin
      alt_eff[i] = alt_in[i];
    end
    if (mem_mode) begin
      alt_eff[pdpc_pkg::P4].own  = pdpc_pkg::ALL_ONE;
      alt_eff[pdpc_pkg::P4].dout = bus_ad_out;
      alt_eff[pdpc_pkg::P4].oe   = {8{bus_ad_oe}};
      alt_eff[pdpc_pkg::P5].own  = pdpc_pkg::ALL_ONE;
      alt_eff[pdpc_pkg::P5].dout = bus_addr_hi;
      alt_eff[pdpc_pkg::P5].oe   = pdpc_pkg::ALL_ONE;
      alt_eff[pdpc_pkg::P6]      = '0;
      alt_eff[pdpc_pkg::P6].own[pdpc_pkg::STB_BIT]  = 1'b1;
      alt_eff[pdpc_pkg::P6].own[pdpc_pkg::WR_BIT]   = 1'b1;
      alt_eff[pdpc_pkg::P6].own[pdpc_pkg::RD_BIT]   = 1'b1;
      alt_eff[pdpc_pkg::P6].own[pdpc_pkg::WAIT_BIT] = wait_en;
      alt_eff[pdpc_pkg::P6].oe[pdpc_pkg::STB_BIT]   = 1'b1;
      alt_eff[pdpc_pkg::P6].oe[pdpc_pkg::WR_BIT]    = 1'b1;
      alt_eff[pdpc_pkg::P6].oe[pdpc_pkg::RD_BIT]    = 1'b1;
      alt_eff[pdpc_pkg::P6].dout[pdpc_pkg::STB_BIT] = bus_astb;
      alt_eff[pdpc_pkg::P6].dout[pdpc_pkg::WR_BIT]  = bus_wr_n;
      alt_eff[pdpc_pkg::P6].dout[pdpc_pkg::RD_BIT]  = bus_rd_n;
    end
  end

  assign key_fall = st.key_prev & ~pin_in[pdpc_pkg::P4];

  always_comb begin
    next_st = st;
    for (int i = 0; i < pdpc_pkg::NPORT; i++) begin
      if (cpu_wr && cpu_addr == pdpc_pkg::DIR_ADDR[i]) begin
        next_st.dir[i] = merge_write(st.dir[i], pdpc_pkg::DIR_MASK[i],
                                     pdpc_pkg::ALL_ONE, cpu_bit, cpu_bit_idx, cpu_wdata);
      end
      if (cpu_wr && cpu_addr == pdpc_pkg::PULL_ADDR[i]) begin
        next_st.pull[i] = merge_write(st.pull[i], pdpc_pkg::PULL_MASK[i],
                                      pdpc_pkg::NONE, cpu_bit, cpu_bit_idx, cpu_wdata);
      end
    end
    // Port 1 addresses are not decoded and read as zero.
    if (cpu_rd) begin
      next_st.rdata = pdpc_pkg::NONE;
      for (int i = 0; i < pdpc_pkg::NPORT; i++) begin
        if (cpu_addr == pdpc_pkg::DIR_ADDR[i]) begin
          next_st.rdata = st.dir[i];
        end
        if (cpu_addr == pdpc_pkg::PULL_ADDR[i]) begin
          next_st.rdata = st.pull[i];
        end
      end
    end
    // Edges made by the bus in expansion mode also count; software owns that case.
    next_st.key_prev = pin_in[pdpc_pkg::P4];
    if (key_flag_clr) begin
      next_st.key_flag = 1'b0;
    end
    if (|key_fall) begin
      next_st.key_flag = 1'b1;
    end
    // The pin level is seen whoever drives it, so own output changes count.
    next_st.p0_prev = pin_in[pdpc_pkg::P0][pdpc_pkg::P0_W-1:0];
    next_st.p0_chg  = st.p0_prev ^ pin_in[pdpc_pkg::P0][pdpc_pkg::P0_W-1:0];
    next_st.cs_n    = pin_in[pdpc_pkg::P8][pdpc_pkg::CS_BIT];
    next_st.tmr     = pin_in[pdpc_pkg::P7][pdpc_pkg::TMR_W-1:0];
    next_st.wait_n  = !(mem_mode && wait_en) ||
                      pin_in[pdpc_pkg::P6][pdpc_pkg::WAIT_BIT];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // One drive stage per port; alternate drive per port covers timer and serial pins.
  for (genvar g = 0; g < pdpc_pkg::NPORT; g++) begin : g_port
    pdpc_port_drive #(
      .DMASK (pdpc_pkg::DIR_MASK[g]),
      .PMASK (pdpc_pkg::PULL_MASK[g])
    ) pdpc_port_drive_inst (
      .clock (clock),
      .rst   (rst),
      .dir   (st.dir[g]),
      .pull  (st.pull[g]),
      .latch (output_latch_regs[g]),
      .alt   (alt_eff[g]),
      .drv   (pins[g])
    );
  end

  assign cpu_rdata             = st.rdata;
  assign key_edge_request_flag = st.key_flag;
  assign port0_change          = st.p0_chg;
  assign chip_select_n         = st.cs_n;
  assign timer_in              = st.tmr;
  assign bus_wait_n            = st.wait_n;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  key_set_a: assert property (
    |key_fall |=> key_edge_request_flag)
    else $error("key edge did not set flag");

  key_hold_a: assert property (
    key_edge_request_flag && !key_flag_clr |=> key_edge_request_flag)
    else $error("key flag lost without clear");

  dir_byte_a: assert property (
    cpu_wr && !cpu_bit && cpu_addr == pdpc_pkg::DIR_ADDR[pdpc_pkg::P4]
    |=> st.dir[pdpc_pkg::P4] == $past(cpu_wdata))
    else $error("byte write to port 4 direction lost");

  dir_bit_a: assert property (
    cpu_wr && cpu_bit && cpu_addr == pdpc_pkg::DIR_ADDR[pdpc_pkg::P5]
    |=> st.dir[pdpc_pkg::P5][$past(cpu_bit_idx)] == $past(cpu_wdata[0]))
    else $error("bit write to port 5 direction lost");

  dir_fixed_a: assert property (
    (st.dir[pdpc_pkg::P8] | pdpc_pkg::DIR_MASK[pdpc_pkg::P8]) == 8'hff)
    else $error("unbuilt direction bit not one");

  pull_fixed_a: assert property (
    (st.pull[pdpc_pkg::P3] & ~pdpc_pkg::PULL_MASK[pdpc_pkg::P3]) == 8'h00)
    else $error("unbuilt pull-up bit not zero");

  input_off_a: assert property (
    !mem_mode && alt_in[pdpc_pkg::P4].own == 8'h00 && st.dir[pdpc_pkg::P4] == 8'hff
    |=> pins[pdpc_pkg::P4].oe == 8'h00)
    else $error("input-mode pin driven");

  output_on_a: assert property (
    !mem_mode && alt_in[pdpc_pkg::P4].own == 8'h00 && st.dir[pdpc_pkg::P4] == 8'h00
    |=> pins[pdpc_pkg::P4].oe == 8'hff
        && pins[pdpc_pkg::P4].dout == $past(output_latch_regs[pdpc_pkg::P4]))
    else $error("output-mode pin not driving latch");

  addr_hi_a: assert property (
    mem_mode |=> pins[pdpc_pkg::P5].oe == 8'hff && pins[pdpc_pkg::P5].dout == $past(bus_addr_hi))
    else $error("upper address not on port 5");

  pull_keep_a: assert property (
    mem_mode |=> pins[pdpc_pkg::P4].pull == $past(st.pull[pdpc_pkg::P4]))
    else $error("pull-up dropped in expansion mode");

  wait_port_a: assert property (
    mem_mode && !wait_en && !st.dir[pdpc_pkg::P6][pdpc_pkg::WAIT_BIT]
    && !alt_in[pdpc_pkg::P6].own[pdpc_pkg::WAIT_BIT]
    |=> pins[pdpc_pkg::P6].oe[pdpc_pkg::WAIT_BIT])
    else $error("wait pin not usable as port");

  unmapped_a: assert property (
    cpu_rd && cpu_addr == 16'hff21 |=> cpu_rdata == 8'h00)
    else $error("port 1 address not reading zero");

  // Register, pull-up and pin checks for the remaining rules.
  key_win_a: assert property (
    |key_fall && key_flag_clr |=> key_edge_request_flag)
    else $error("key clear beat a new edge");

  key_clr_a: assert property (
    !(|key_fall) && key_flag_clr |=> !key_edge_request_flag)
    else $error("key flag not cleared");

  dir_keep_a: assert property (
    cpu_wr && cpu_bit && cpu_addr == pdpc_pkg::DIR_ADDR[pdpc_pkg::P5]
    |=> ((st.dir[pdpc_pkg::P5] ^ $past(st.dir[pdpc_pkg::P5]))
         & ~(8'h01 << $past(cpu_bit_idx))) == 8'h00)
    else $error("bit write disturbed other direction bits");

  dir_hold_a: assert property (
    !cpu_wr |=> $stable(st.dir))
    else $error("direction changed without write");

  pull_byte_a: assert property (
    cpu_wr && !cpu_bit && cpu_addr == pdpc_pkg::PULL_ADDR[pdpc_pkg::P5]
    |=> st.pull[pdpc_pkg::P5] == $past(cpu_wdata))
    else $error("byte write to port 5 pull-up lost");

  pull_hold_a: assert property (
    !cpu_wr |=> $stable(st.pull))
    else $error("pull-up changed without write");

  rd_dir_a: assert property (
    cpu_rd && cpu_addr == pdpc_pkg::DIR_ADDR[pdpc_pkg::P0]
    |=> (cpu_rdata | pdpc_pkg::DIR_MASK[pdpc_pkg::P0]) == 8'hff)
    else $error("unbuilt direction bit read wrong");

  rd_pull_a: assert property (
    cpu_rd && cpu_addr == pdpc_pkg::PULL_ADDR[pdpc_pkg::P0]
    |=> (cpu_rdata & ~pdpc_pkg::PULL_MASK[pdpc_pkg::P0]) == 8'h00)
    else $error("unbuilt pull-up bit read wrong");

  p4_dir_a: assert property (
    !mem_mode && alt_in[pdpc_pkg::P4].own == 8'h00
    |=> pins[pdpc_pkg::P4].oe == ~$past(st.dir[pdpc_pkg::P4]))
    else $error("port 4 pin direction wrong");

  pull_on_a: assert property (
    st.pull[pdpc_pkg::P8][pdpc_pkg::CS_BIT] |=> pins[pdpc_pkg::P8].pull[pdpc_pkg::CS_BIT])
    else $error("selected pull-up not connected");

  pull_dir_a: assert property (
    st.pull[pdpc_pkg::P6][pdpc_pkg::RD_BIT] && !st.dir[pdpc_pkg::P6][pdpc_pkg::RD_BIT]
    |=> pins[pdpc_pkg::P6].pull[pdpc_pkg::RD_BIT])
    else $error("pull-up dropped in output mode");

  pull_bus_a: assert property (
    mem_mode |=> pins[pdpc_pkg::P6].pull == $past(st.pull[pdpc_pkg::P6])
             && pins[pdpc_pkg::P5].pull == $past(st.pull[pdpc_pkg::P5]))
    else $error("bus pin pull-up dropped");

  mux_bus_a: assert property (
    mem_mode |=> pins[pdpc_pkg::P4].dout == $past(bus_ad_out)
             && pins[pdpc_pkg::P4].oe == {8{$past(bus_ad_oe)}})
    else $error("muxed bus not on port 4");

  ctl_pins_a: assert property (
    mem_mode |=> pins[pdpc_pkg::P6].oe[pdpc_pkg::STB_BIT]
             && pins[pdpc_pkg::P6].dout[pdpc_pkg::RD_BIT] == $past(bus_rd_n))
    else $error("bus control not on port 6");

  wait_in_a: assert property (
    mem_mode && wait_en |=> !pins[pdpc_pkg::P6].oe[pdpc_pkg::WAIT_BIT])
    else $error("wait pin driven while wait used");

  wait_idle_a: assert property (
    !(mem_mode && wait_en) |=> bus_wait_n)
    else $error("wait asserted while not used");

  tmr_copy_a: assert property (
    !rst |=> timer_in == $past(pin_in[pdpc_pkg::P7][pdpc_pkg::TMR_W-1:0]))
    else $error("timer input not following pins");

  cs_copy_a: assert property (
    !rst |=> chip_select_n == $past(pin_in[pdpc_pkg::P8][pdpc_pkg::CS_BIT]))
    else $error("chip select not following pin");

  p8_only_a: assert property (
    (pins[pdpc_pkg::P8].oe & ~pdpc_pkg::DIR_MASK[pdpc_pkg::P8]) == 8'h00)
    else $error("unbuilt port 8 pin driven");

  alt_drive_a: assert property (
    !mem_mode && alt_in[pdpc_pkg::P7].own[0]
    |=> pins[pdpc_pkg::P7].dout[0] == $past(alt_in[pdpc_pkg::P7].dout[0]))
    else $error("alternate output not on pin");

  p0_chg_a: assert property (
    !$past(rst) && pin_in[pdpc_pkg::P0][0] != $past(pin_in[pdpc_pkg::P0][0])
    |=> port0_change[0])
    else $error("port 0 level change not flagged");

  key_cov: cover property (|key_fall ##1 key_edge_request_flag);
  bus_cov: cover property (mem_mode && bus_ad_oe ##1 pins[pdpc_pkg::P4].oe == 8'hff);
  bitw_cov: cover property (cpu_wr && cpu_bit ##1 cpu_rd);
  wait_cov: cover property (mem_mode && wait_en ##1 !bus_wait_n);
  chg_cov: cover property (port0_change[0]);

endmodule : pdpc_top

/* File: bench/pdpc_pin_model.sv */
`timescale 1ns/1ps
module pdpc_pin_model (
  // Pin drive from the device.
  input  wire pdpc_pkg::pdpc_drive_s [pdpc_pkg::NPORT-1:0] pins,
  // Level the board puts on a pin that nobody drives or pulls.
  input  wire logic [pdpc_pkg::NPORT-1:0][7:0]            ext_level,
  // Resolved pin levels.
  output logic [pdpc_pkg::NPORT-1:0][7:0]                 pin_in
);
  // A connected pull-up wins over the board only while the device does not drive.
  always_comb begin
    for (int i = 0; i < pdpc_pkg::NPORT; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (pins[i].oe[b]) begin
          pin_in[i][b] = pins[i].dout[b];
        end else if (pins[i].pull[b]) begin
          pin_in[i][b] = 1'b1;
        end else begin
          pin_in[i][b] = ext_level[i][b];
        end
      end
    end
  end
endmodule : pdpc_pin_model

/* File: bench/port_direction_pullup_control_bench.sv */
`timescale 1ns/1ps
module port_direction_pullup_control_bench;
  localparam logic [7:0]  DM  [8] = '{8'h0f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hf0, 8'h3f, 8'h01};
  localparam logic [7:0]  PM  [8] = '{8'h0f, 8'h3f, 8'h70, 8'hff, 8'hff, 8'hf0, 8'h3f, 8'h01};
  localparam logic [15:0] ADR [8] = '{16'hff20, 16'hff22, 16'hff23, 16'hff24,
                                      16'hff25, 16'hff26, 16'hff27, 16'hff28};
  logic                                        clock = 1'b0;
  logic                                        rst = 1'b1;
  logic [15:0]                                 cpu_addr = 16'h0000;
  logic                                        cpu_wr = 1'b0;
  logic                                        cpu_rd = 1'b0;
  logic                                        cpu_bit = 1'b0;
  logic [2:0]                                  cpu_bit_idx = 3'h0;
  logic [7:0]                                  cpu_wdata = 8'h00;
  logic [7:0]                                  cpu_rdata;
  logic [pdpc_pkg::NPORT-1:0][7:0]             latch = '0;
  pdpc_pkg::pdpc_alt_s [pdpc_pkg::NPORT-1:0]   alt_in = '0;
  logic                                        mem_mode = 1'b0;
  logic                                        wait_en = 1'b0;
  logic [7:0]                                  bus_ad_out = 8'h00;
  logic                                        bus_ad_oe = 1'b0;
  logic [7:0]                                  bus_addr_hi = 8'h00;
  logic                                        bus_rd_n = 1'b1;
  logic                                        bus_wr_n = 1'b1;
  logic                                        bus_astb = 1'b0;
  logic                                        bus_wait_n;
  logic [pdpc_pkg::NPORT-1:0][7:0]             pin_in;
  logic [pdpc_pkg::NPORT-1:0][7:0]             ext_level = '1;
  pdpc_pkg::pdpc_drive_s [pdpc_pkg::NPORT-1:0] pins;
  logic                                        key_flag_clr = 1'b0;
  logic                                        key_edge_request_flag;
  logic [pdpc_pkg::P0_W-1:0]                   port0_change;
  logic                                        chip_select_n;
  logic [pdpc_pkg::TMR_W-1:0]                  timer_in;
  int                                          error_cnt = 0;
  int                                          n_checks = 0;
  int                                          chg_cnt = 0;
  int                                          seed = 45;
  logic [7:0]                                  dsh [8];
  logic [7:0]                                  psh [8];
  logic [7:0]                                  d;
  logic [7:0]                                  pu4;
  logic                                        b;
  logic [2:0]                                  ix;

  pdpc_top pdpc_top_inst (
    .clock(clock), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_bit(cpu_bit), .cpu_bit_idx(cpu_bit_idx), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .output_latch_regs(latch), .alt_in(alt_in),
    .mem_mode(mem_mode), .wait_en(wait_en), .bus_ad_out(bus_ad_out), .bus_ad_oe(bus_ad_oe),
    .bus_addr_hi(bus_addr_hi), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_astb(bus_astb), .bus_wait_n(bus_wait_n), .pin_in(pin_in), .pins(pins),
    .key_flag_clr(key_flag_clr), .key_edge_request_flag(key_edge_request_flag),
    .port0_change(port0_change), .chip_select_n(chip_select_n), .timer_in(timer_in));

  pdpc_pin_model pdpc_pin_model_inst (.pins(pins), .ext_level(ext_level), .pin_in(pin_in));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    if (port0_change[0] === 1'b1) begin
      chg_cnt <= chg_cnt + 1;
    end
  end

  function automatic logic [7:0] calc_reg(input logic [7:0] old, input logic [7:0] mask,
                                          input logic [7:0] fill, input logic bop,
                                          input logic [2:0] idx, input logic [7:0] wd);
    logic [7:0] n;
    n = bop ? old : wd;
    if (bop) begin
      n[idx] = wd[0];
    end
    return (n & mask) | (fill & ~mask);
  endfunction : calc_reg

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered at a falling edge; the strobe covers exactly one rising edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] wd, input logic bop,
                    input logic [2:0] idx);
    cpu_addr = a;
    cpu_wdata = wd;
    cpu_bit = bop;
    cpu_bit_idx = idx;
    cpu_wr = 1'b1;
    @(negedge clock);
    cpu_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clock);
    cpu_rd = 1'b0;
    @(negedge clock);
    chk(cpu_rdata, exp);
  endtask : rd

  task automatic settle;
    repeat (2) @(negedge clock);
  endtask : settle

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      dsh[i] = 8'hff;
      psh[i] = 8'h00;
      rd(ADR[i], 8'hff);
      rd(ADR[i] + 16'h0010, 8'h00);
      chk(pins[i].oe, 8'h00);
    end
    rd(16'hff21, 8'h00);
    wr(16'hff31, 8'hff, 1'b0, 3'h0);
    rd(16'hff31, 8'h00);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) begin
        d = (k == 0) ? 8'h00 : 8'($random(seed));
        b = (k == 0) ? 1'b0 : 1'($random(seed));
        ix = 3'($random(seed));
        dsh[i] = calc_reg(dsh[i], DM[i], 8'hff, b, ix, d);
        wr(ADR[i], d, b, ix);
        rd(ADR[i], dsh[i]);
        d = (k == 0) ? 8'hff : 8'($random(seed));
        psh[i] = calc_reg(psh[i], PM[i], 8'h00, b, ix, d);
        wr(ADR[i] + 16'h0010, d, b, ix);
        rd(ADR[i] + 16'h0010, psh[i]);
      end
    end
    for (int i = 0; i < 8; i++) begin
      latch[i] = 8'($random(seed));
    end
    settle();
    for (int i = 0; i < 8; i++) begin
      chk(pins[i].oe, ~dsh[i]);
      chk(pins[i].dout & ~dsh[i], latch[i] & ~dsh[i]);
      chk(pins[i].pull, psh[i]);
    end
    // The alternate output pin keeps its latch at zero.
    wr(16'hff27, 8'h00, 1'b1, 3'h0);
    latch[6][0] = 1'b0;
    alt_in[6] = '{own: 8'h01, dout: 8'h01, oe: 8'h01};
    settle();
    chk({7'h00, pins[6].dout[0] & pins[6].oe[0]}, 8'h01);
    alt_in[6] = '0;
    wr(16'hff27, 8'hff, 1'b0, 3'h0);
    wr(16'hff37, 8'h00, 1'b0, 3'h0);
    wr(16'hff28, 8'hff, 1'b0, 3'h0);
    wr(16'hff38, 8'h00, 1'b0, 3'h0);
    ext_level[6] = 8'($random(seed));
    ext_level[7] = 8'h00;
    settle();
    chk({2'b00, timer_in}, {2'b00, ext_level[6][5:0]});
    chk({7'h00, chip_select_n}, 8'h00);
    mem_mode = 1'b0;
    wr(16'hff24, 8'hff, 1'b0, 3'h0);
    wr(16'hff34, 8'h00, 1'b0, 3'h0);
    ext_level[3] = 8'hff;
    key_flag_clr = 1'b1;
    settle();
    key_flag_clr = 1'b0;
    @(negedge clock);
    chk({7'h00, key_edge_request_flag}, 8'h00);
    ext_level[3][5] = 1'b0;
    settle();
    chk({7'h00, key_edge_request_flag}, 8'h01);
    key_flag_clr = 1'b1;
    @(negedge clock);
    key_flag_clr = 1'b0;
    @(negedge clock);
    chk({7'h00, key_edge_request_flag}, 8'h00);
    wr(16'hff20, 8'h00, 1'b0, 3'h0);
    wr(16'hff30, 8'h00, 1'b0, 3'h0);
    latch[0] = 8'h00;
    settle();
    settle();
    chg_cnt = 0;
    latch[0][0] = 1'b1;
    repeat (4) @(negedge clock);
    chk(8'(chg_cnt), 8'h01);
    pu4 = 8'($random(seed));
    wr(16'hff34, pu4, 1'b0, 3'h0);
    wr(16'hff36, 8'hb0, 1'b0, 3'h0);
    mem_mode = 1'b1;
    wait_en = 1'b1;
    bus_ad_oe = 1'b1;
    bus_ad_out = 8'($random(seed));
    bus_addr_hi = 8'($random(seed));
    bus_rd_n = 1'b0;
    ext_level[5][6] = 1'b0;
    settle();
    chk(pins[3].oe, 8'hff);
    chk(pins[3].dout, bus_ad_out);
    chk(pins[3].pull, pu4);
    chk(pins[4].oe, 8'hff);
    chk(pins[4].dout, bus_addr_hi);
    chk(pins[5].oe & 8'hb0, 8'hb0);
    chk(pins[5].dout & 8'hb0, 8'h20);
    chk(pins[5].pull, 8'hb0);
    chk({7'h00, bus_wait_n}, 8'h00);
    bus_ad_oe = 1'b0;
    wait_en = 1'b0;
    wr(16'hff26, 8'hbf, 1'b0, 3'h0);
    latch[5][6] = 1'b1;
    settle();
    chk(pins[3].oe, 8'h00);
    chk({7'h00, bus_wait_n}, 8'h01);
    chk(pins[5].oe & pins[5].dout & 8'h40, 8'h40);
    give_verdict();
  end
endmodule : port_direction_pullup_control_bench
